// File: rtl/tcvf_framer.sv
// Purpose: telecommand verification report framer with reception timeout
// Assumes: receiver events synchronous to clk, one telecommand at a time
// Notes: report bytes leave through a FIFO, header first, msb first
// Summary of operation
// - Reception not finished within 2 s gives an incomplete-packet failure report.
// - Received checksum differing from computed one gives an incorrect-checksum report.
// - Every report carries process id 71 and packet category 1 (event).
// - Service type field is 1, telecommand verification, in every report.
// - Failure reports carry service subtype 2, acceptance failure.
// - PUS version field holds the non-science value.
// - 14-bit source sequence counter, zero at start, one per stream.
// - Time field: four bytes seconds then two bytes fraction.
// - Time is latched when reception of the telecommand begins.
// - Success source data: process id word then sequence control word.
// - Incomplete source data: id, seqctl, code 1, service, length, byte count.
// - Service info word holds the telecommand's service type and subtype.
// - Sequence control word copies the telecommand's segmentation and counter.
// - Acceptance success report uses service type 1, subtype 1.
// - Checksum source data: id, seqctl, code 2, service, received, computed.
// - Packet length field equals source data bytes plus nine.
module tcvf_framer #(
  parameter int unsigned TIMEOUT = tcvf_pkg::TIMEOUT_CYCLES,
  parameter int DEPTH = tcvf_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // on-board time
  input wire logic [31:0] time_coarse,
  input wire logic [15:0] time_fine,
  // telecommand receiver events
  input wire logic tc_start,
  input wire logic tc_byte,
  input wire logic tc_header_valid,
  input wire logic [15:0] tc_gpid,
  input wire logic [15:0] tc_seq_ctrl,
  input wire logic [7:0] tc_service_type,
  input wire logic [7:0] tc_service_subtype,
  input wire logic [15:0] tc_declared_length,
  input wire logic tc_end,
  input wire logic [15:0] tc_received_checksum,
  input wire logic [15:0] tc_computed_checksum,
  output logic tc_busy,
  // report byte stream
  output logic report_valid,
  input wire logic report_ready,
  output logic [7:0] report_data
);
  import tcvf_pkg::*;

  logic rst_meta;
  logic rst_n;
  tcvf_state_type state;
  tcvf_kind_type kind;
  logic [31:0] timer;
  logic timed_out;
  logic [31:0] latch_coarse;
  logic [15:0] latch_fine;
  logic [15:0] global_process_id_word;
  logic [15:0] sequence_control_word;
  logic [15:0] service_info_word;
  logic [15:0] declared_length_word;
  logic [15:0] received_byte_count_word;
  logic [15:0] received_checksum_word;
  logic [15:0] computed_checksum_word;
  logic [13:0] source_sequence_count;
  logic [FRAME_BITS-1:0] frame;
  logic [FRAME_BITS-1:0] next_frame;
  logic [4:0] bytes_left;
  logic [4:0] src_bytes;
  logic [15:0] packet_length_field;
  logic [47:0] acquisition_time_field;
  logic [7:0] service_subtype_field;
  logic [95:0] source_data;
  logic [127:0] header;
  logic push;

  tcvf_byte_if #(.WIDTH(8)) fifo_in ();

  // reset release through two flops so all flops leave reset together
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign timed_out = (timer == TIMEOUT - 32'd1);
  assign tc_busy = (state != ST_IDLE);

  // main sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      kind <= KIND_SUCCESS;
    end else begin
      case (state)
        ST_IDLE: begin
          if (tc_start) begin
            state <= ST_RECV;
          end
        end
        ST_RECV: begin
          // completion wins over a timeout in the same cycle
          if (tc_end) begin
            state <= ST_LOAD;
            if (tc_received_checksum != tc_computed_checksum) begin
              kind <= KIND_CHECKSUM;
            end else begin
              kind <= KIND_SUCCESS;
            end
          end else if (timed_out) begin
            state <= ST_LOAD;
            kind <= KIND_INCOMPLETE;
          end
        end
        ST_LOAD: begin
          state <= ST_SEND;
        end
        ST_SEND: begin
          if (push && bytes_left == 5'h01) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // reception timer, cleared while idle and restarted only by a start accepted in idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer <= '0;
    end else if (state == ST_IDLE) begin
      timer <= '0;
    end else if (state == ST_RECV && !timed_out) begin
      timer <= timer + 32'd1;
    end
  end

  // time of acquisition start, not of transmission
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_coarse <= '0;
      latch_fine <= '0;
    end else if (state == ST_IDLE && tc_start) begin
      latch_coarse <= time_coarse;
      latch_fine <= time_fine;
    end
  end

  // telecommand identity, cleared at start so a lost header reports zeros
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_process_id_word <= '0;
      sequence_control_word <= '0;
      service_info_word <= '0;
      declared_length_word <= '0;
    end else if (state == ST_IDLE && tc_start) begin
      global_process_id_word <= '0;
      sequence_control_word <= '0;
      service_info_word <= '0;
      declared_length_word <= '0;
    end else if (state == ST_RECV && tc_header_valid) begin
      global_process_id_word <= tc_gpid;
      sequence_control_word <= tc_seq_ctrl;
      service_info_word <= {tc_service_type, tc_service_subtype};
      declared_length_word <= tc_declared_length;
    end
  end

  // byte count saturates rather than wrapping on an overlong command
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      received_byte_count_word <= '0;
    end else if (state == ST_IDLE && tc_start) begin
      received_byte_count_word <= '0;
    end else if (state == ST_RECV && tc_byte && received_byte_count_word != 16'hFFFF) begin
      received_byte_count_word <= received_byte_count_word + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      received_checksum_word <= '0;
      computed_checksum_word <= '0;
    end else if (state == ST_RECV && tc_end) begin
      received_checksum_word <= tc_received_checksum;
      computed_checksum_word <= tc_computed_checksum;
    end
  end

  // only the event stream of this process exists here, so one counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      source_sequence_count <= SEQ_RESET;
    end else if (state == ST_LOAD) begin
      source_sequence_count <= source_sequence_count + 14'h0001;
    end
  end

  // frame assembly
  always_comb begin
    src_bytes = SRC_BYTES_FAILURE;
    service_subtype_field = SUBTYPE_ACCEPT_FAIL;
    case (kind)
      KIND_SUCCESS: begin
        src_bytes = SRC_BYTES_SUCCESS;
        service_subtype_field = SUBTYPE_ACCEPT_OK;
        source_data = {global_process_id_word, sequence_control_word, 64'h0};
      end
      KIND_INCOMPLETE: begin
        source_data = {global_process_id_word, sequence_control_word,
                       FAIL_CODE_INCOMPLETE, service_info_word,
                       declared_length_word, received_byte_count_word};
      end
      KIND_CHECKSUM: begin
        source_data = {global_process_id_word, sequence_control_word,
                       FAIL_CODE_CHECKSUM, service_info_word,
                       received_checksum_word, computed_checksum_word};
      end
      default: begin
        source_data = '0;
      end
    endcase
  end

  assign packet_length_field = {11'h000, src_bytes} + LENGTH_ADJUST;
  assign acquisition_time_field = {latch_coarse, latch_fine};

  // flag, spare and pad are held at zero
  assign header = {VERSION_NUMBER, PACKET_TYPE_BIT, DATA_HEADER_FLAG,
                   REPORT_APID, CATEGORY_EVENT,
                   SEGMENT_STANDALONE, source_sequence_count,
                   packet_length_field, acquisition_time_field,
                   PUS_NON_SCIENCE, 1'b0, 4'h0,
                   SERVICE_VERIFICATION, service_subtype_field, 8'h00};

  // a wide shift register sends the frame top byte first
  always_comb begin
    next_frame = frame;
    if (state == ST_LOAD) begin
      next_frame = {header, source_data};
    end else if (push) begin
      next_frame = {frame[FRAME_BITS-9:0], 8'h00};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bytes_left <= '0;
    end else if (state == ST_LOAD) begin
      bytes_left <= HEADER_BYTES + src_bytes;
    end else if (push) begin
      bytes_left <= bytes_left - 5'h01;
    end
  end

  // a full buffer stalls the shift register, never drops a byte
  assign fifo_in.valid = (state == ST_SEND);
  assign fifo_in.data = frame[FRAME_BITS-1 -: 8];
  assign push = fifo_in.valid && fifo_in.ready;

  tcvf_fifo #(
    .WIDTH(8),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_if(fifo_in),
    .out_valid(report_valid),
    .out_ready(report_ready),
    .out_data(report_data)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_loaded;
    state == ST_LOAD ##1 state == ST_SEND;
  endsequence

  sequence s_bad_end;
    state == ST_RECV && tc_end && (tc_received_checksum != tc_computed_checksum);
  endsequence

  a_apid_category_fixed: assert property (
    s_loaded |-> frame[POS_APID +: 7] == 7'h47 && frame[POS_CATEGORY +: 4] == 4'h1)
    else $error("report apid or category wrong");

  a_service_type_value: assert property (
    s_loaded |-> frame[POS_STYPE +: 8] == 8'h01)
    else $error("service type not verification");

  a_failure_subtype_two: assert property (
    state == ST_LOAD && kind != KIND_SUCCESS |=> frame[POS_SUBTYPE +: 8] == 8'h02)
    else $error("failure report subtype not 2");

  a_success_subtype_one: assert property (
    state == ST_LOAD && kind == KIND_SUCCESS |=> frame[POS_SUBTYPE +: 8] == 8'h01
      && frame[95:64] == {global_process_id_word, sequence_control_word})
    else $error("success report subtype or data wrong");

  a_pus_pad_zero: assert property (
    s_loaded |-> frame[POS_PUS +: 3] == 3'h2 && frame[124:120] == 5'h00
      && frame[103:96] == 8'h00)
    else $error("pus version or zero fields wrong");

  // expected lengths are 4 + 9 and 12 + 9, kept apart from the byte counter
  a_length_plus_nine: assert property (
    s_loaded |-> frame[POS_LENGTH +: 16]
      == ((kind == KIND_SUCCESS) ? 16'h000D : 16'h0015))
    else $error("packet length field not source bytes plus nine");

  a_seq_counter_step: assert property (
    state == ST_LOAD |=> source_sequence_count == $past(source_sequence_count) + 14'h0001
      && frame[POS_SEQ +: 14] == $past(source_sequence_count))
    else $error("sequence counter did not step");

  a_timeout_reports: assert property (
    state == ST_RECV && timed_out && !tc_end |=> state == ST_LOAD
      ##1 frame[POS_FAIL_CODE +: 16] == 16'h0001
      && frame[15:0] == received_byte_count_word)
    else $error("timeout did not give incomplete report");

  a_checksum_reports: assert property (
    s_bad_end |=> kind == KIND_CHECKSUM ##1 frame[POS_FAIL_CODE +: 16] == 16'h0002
      && frame[15:0] == computed_checksum_word)
    else $error("bad checksum did not give checksum report");

  a_time_at_start: assert property (
    state == ST_IDLE && tc_start |=> latch_coarse == $past(time_coarse)
      && latch_fine == $past(time_fine))
    else $error("time not latched at reception start");

  a_time_in_frame: assert property (
    s_loaded |-> frame[POS_COARSE +: 32] == latch_coarse
      && frame[POS_FINE +: 16] == latch_fine)
    else $error("time field does not hold latched time");

  a_service_info_copy: assert property (
    state == ST_RECV && tc_header_valid |=>
      service_info_word == {$past(tc_service_type), $past(tc_service_subtype)})
    else $error("service info not copied");

endmodule : tcvf_framer

// File: rtl/tcvf_pkg.sv
// Purpose: shared constants and types of the verification report framer
// Assumes: 100 MHz system clock
// Notes: field positions count from bit 0 of the 224-bit report frame
package tcvf_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TIMEOUT_MS = 2000;
  localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  // primary header constants
  localparam logic [2:0] VERSION_NUMBER = 3'h0;
  localparam logic PACKET_TYPE_BIT = 1'h0;
  localparam logic DATA_HEADER_FLAG = 1'h1;
  localparam logic [6:0] REPORT_APID = 7'h47;
  localparam logic [3:0] CATEGORY_EVENT = 4'h1;
  localparam logic [1:0] SEGMENT_STANDALONE = 2'h3;
  // data field header constants
  localparam logic [2:0] PUS_NON_SCIENCE = 3'h2;
  localparam logic [7:0] SERVICE_VERIFICATION = 8'h01;
  localparam logic [7:0] SUBTYPE_ACCEPT_OK = 8'h01;
  localparam logic [7:0] SUBTYPE_ACCEPT_FAIL = 8'h02;
  localparam logic [15:0] FAIL_CODE_INCOMPLETE = 16'h0001;
  localparam logic [15:0] FAIL_CODE_CHECKSUM = 16'h0002;
  // sizes in bytes
  localparam logic [4:0] HEADER_BYTES = 5'h10;
  localparam logic [4:0] SRC_BYTES_SUCCESS = 5'h04;
  localparam logic [4:0] SRC_BYTES_FAILURE = 5'h0C;
  localparam logic [15:0] LENGTH_ADJUST = 16'h0009;
  localparam int unsigned FRAME_BITS = 224;
  // field positions in the frame
  localparam int unsigned POS_APID = 212;
  localparam int unsigned POS_CATEGORY = 208;
  localparam int unsigned POS_SEQ = 192;
  localparam int unsigned POS_LENGTH = 176;
  localparam int unsigned POS_COARSE = 144;
  localparam int unsigned POS_FINE = 128;
  localparam int unsigned POS_PUS = 125;
  localparam int unsigned POS_STYPE = 112;
  localparam int unsigned POS_SUBTYPE = 104;
  localparam int unsigned POS_FAIL_CODE = 48;
  localparam logic [13:0] SEQ_RESET = 14'h0000;
  localparam int unsigned FIFO_DEPTH = 16;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_LOAD = 2'b10,
    ST_SEND = 2'b11
  } tcvf_state_type;
  typedef enum logic [1:0] {
    KIND_SUCCESS = 2'b00,
    KIND_INCOMPLETE = 2'b01,
    KIND_CHECKSUM = 2'b10
  } tcvf_kind_type;
endpackage : tcvf_pkg

// File: rtl/tcvf_byte_if.sv
// Purpose: byte stream between the framer and its output buffer
// Assumes: valid/ready handshake, transfer when both high
// Notes: none
interface tcvf_byte_if #(parameter int WIDTH = 8);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : tcvf_byte_if

// File: rtl/tcvf_fifo.sv
// Purpose: flip-flop FIFO buffering report bytes toward the consumer
// Assumes: single clock, active-low asynchronous reset already synchronised
// Notes: DEPTH must be a power of two
module tcvf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // filling side
  tcvf_byte_if.snk in_if,
  // draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_if.ready = !full;
  assign out_valid = !empty;
  assign push = in_if.valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_if.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : tcvf_fifo

// File: verif/tcvf_sink.sv
// Purpose: behavioural consumer of the report byte stream
// Assumes: ready changes on the falling edge, bytes taken on the rising edge
// Notes: stall lets the bench hold the stream off to fill the buffer
module tcvf_sink (
  // clock
  input wire logic clk,
  // report stream
  input wire logic report_valid,
  input wire logic [7:0] report_data,
  output logic report_ready,
  // bench control
  input wire logic stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] bytes [$];

  initial report_ready = 1'b0;

  // ready moves off the sampling edge so the capture below never races it
  always @(negedge clk) begin
    report_ready <= !stall;
  end

  always @(posedge clk) begin
    if (report_valid && report_ready) begin
      bytes.push_back(report_data);
    end
  end
endmodule : tcvf_sink

// File: verif/tcvf_framer_bench.sv
// Purpose: self-checking bench of the verification report framer
// Assumes: short reception timeout parameter, consumer model on the stream
// Notes: expected frames are built here from field values, never from the design
module tcvf_framer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tcvf_pkg::*;
  // short timeout keeps the run brief; expectations do not depend on it
  localparam int unsigned TMO = 50;
  logic clk, reset_n, tc_start, tc_byte, tc_header_valid, tc_end, tc_busy;
  logic [31:0] time_coarse;
  logic [15:0] time_fine, tc_gpid, tc_seq_ctrl, tc_declared_length;
  logic [15:0] tc_received_checksum, tc_computed_checksum;
  logic [7:0] tc_service_type, tc_service_subtype, report_data;
  logic report_valid, report_ready, stall;
  int fails = 0;
  int check_count = 0;

  tcvf_framer #(.TIMEOUT(TMO), .DEPTH(16)) i_tcvf_framer (
    .clk(clk), .reset_n(reset_n), .time_coarse(time_coarse), .time_fine(time_fine),
    .tc_start(tc_start), .tc_byte(tc_byte), .tc_header_valid(tc_header_valid),
    .tc_gpid(tc_gpid), .tc_seq_ctrl(tc_seq_ctrl), .tc_service_type(tc_service_type),
    .tc_service_subtype(tc_service_subtype), .tc_declared_length(tc_declared_length),
    .tc_end(tc_end), .tc_received_checksum(tc_received_checksum),
    .tc_computed_checksum(tc_computed_checksum), .tc_busy(tc_busy),
    .report_valid(report_valid), .report_ready(report_ready), .report_data(report_data));

  tcvf_sink i_tcvf_sink (
    .clk(clk), .report_valid(report_valid), .report_data(report_data),
    .report_ready(report_ready), .stall(stall));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check_bit

  // whole report image, msb first; a success report uses only the top 20 bytes
  function automatic logic [223:0] frame(input logic [7:0] sub, input logic [13:0] seq,
      input logic [15:0] len, input logic [31:0] sec, input logic [15:0] frac,
      input logic [95:0] src);
    return {3'h0, 1'h0, 1'h1, 7'h47, 4'h1, 2'h3, seq, len, sec, frac,
            3'h2, 1'h0, 4'h0, 8'h01, sub, 8'h00, src};
  endfunction : frame

  task automatic send_tc(input logic [15:0] gpid, input logic [15:0] seqc,
      input logic [7:0] st, input logic [7:0] sb, input logic [15:0] dlen, input int n,
      input logic fin, input logic [15:0] rc, input logic [15:0] cc,
      input logic [31:0] sec, input logic [15:0] frac);
    int k;
    for (k = 0; k < 3000 && tc_busy !== 1'b0; k++) @(negedge clk);
    if (tc_busy !== 1'b0) begin
      check_bit(tc_busy, 1'b0);
      stop_test();
    end
    time_coarse = sec;
    time_fine = frac;
    tc_start = 1'b1;
    @(negedge clk);
    tc_start = 1'b0;
    // time moves on during reception; the report must keep the start value
    time_coarse = ~sec;
    time_fine = ~frac;
    tc_header_valid = 1'b1;
    tc_gpid = gpid;
    tc_seq_ctrl = seqc;
    tc_service_type = st;
    tc_service_subtype = sb;
    tc_declared_length = dlen;
    @(negedge clk);
    tc_header_valid = 1'b0;
    tc_byte = 1'b1;
    repeat (n) @(negedge clk);
    tc_byte = 1'b0;
    if (fin) begin
      tc_end = 1'b1;
      tc_received_checksum = rc;
      tc_computed_checksum = cc;
      @(negedge clk);
      tc_end = 1'b0;
    end
  endtask : send_tc

  task automatic check_report(input logic [223:0] exp, input int n);
    int k;
    for (k = 0; k < 3000 && i_tcvf_sink.bytes.size() < n; k++) @(negedge clk);
    if (i_tcvf_sink.bytes.size() < n) begin
      check_byte(8'(i_tcvf_sink.bytes.size()), 8'(n));
      stop_test();
    end
    repeat (5) @(negedge clk);
    check_byte(8'(i_tcvf_sink.bytes.size()), 8'(n));
    for (k = 0; k < n; k++) begin
      check_byte(i_tcvf_sink.bytes[k], exp[223 - 8 * k -: 8]);
    end
    check_bit(report_valid, 1'b0);
    check_bit(tc_busy, 1'b0);
    i_tcvf_sink.bytes.delete();
  endtask : check_report

  task automatic sc_success();
    stall = 1'b0;
    send_tc(16'h0A5C, 16'hC123, 8'h11, 8'h22, 16'h000B, 12, 1'b1, 16'hBEEF, 16'hBEEF,
            32'h1234_5678, 16'h9ABC);
    check_report(frame(8'h01, 14'h0000, 16'h000D, 32'h1234_5678, 16'h9ABC,
                       {16'h0A5C, 16'hC123, 64'h0}), 20);
  endtask : sc_success

  task automatic sc_checksum_stall();
    stall = 1'b1;
    send_tc(16'h3F01, 16'h4ABC, 8'h08, 8'h05, 16'h0020, 3, 1'b1, 16'h1357, 16'h2468,
            32'hFFFF_FFFE, 16'h0001);
    repeat (40) @(negedge clk);
    // 28 bytes cannot fit the 16-deep buffer, so the framer must still be busy
    check_bit(tc_busy, 1'b1);
    check_bit(report_valid, 1'b1);
    check_byte(8'(i_tcvf_sink.bytes.size()), 8'h00);
    stall = 1'b0;
    check_report(frame(8'h02, 14'h0001, 16'h0015, 32'hFFFF_FFFE, 16'h0001,
                       {16'h3F01, 16'h4ABC, 16'h0002, 16'h0805, 16'h1357, 16'h2468}),
                 28);
  endtask : sc_checksum_stall

  task automatic sc_timeout();
    stall = 1'b0;
    send_tc(16'h00FF, 16'h8001, 8'h11, 8'h80, 16'h0040, 5, 1'b0, 16'h0, 16'h0,
            32'h0000_0100, 16'h8000);
    // a second start during reception is refused and must not clear the header
    tc_start = 1'b1;
    @(negedge clk);
    tc_start = 1'b0;
    check_report(frame(8'h02, 14'h0002, 16'h0015, 32'h0000_0100, 16'h8000,
                       {16'h00FF, 16'h8001, 16'h0001, 16'h1180, 16'h0040, 16'h0005}),
                 28);
  endtask : sc_timeout

  initial begin
    reset_n = 1'b0;
    stall = 1'b0;
    tc_start = 1'b0;
    tc_byte = 1'b0;
    tc_header_valid = 1'b0;
    tc_end = 1'b0;
    time_coarse = 32'h0;
    time_fine = 16'h0;
    tc_gpid = 16'h0;
    tc_seq_ctrl = 16'h0;
    tc_service_type = 8'h0;
    tc_service_subtype = 8'h0;
    tc_declared_length = 16'h0;
    tc_received_checksum = 16'h0;
    tc_computed_checksum = 16'h0;
    repeat (20) @(negedge clk);
    check_bit(tc_busy, 1'b0);
    check_bit(report_valid, 1'b0);
    reset_n = 1'b1;
    repeat (3) @(negedge clk);
    sc_success();
    sc_checksum_stall();
    sc_timeout();
    stop_test();
  end
endmodule : tcvf_framer_bench
